//--- core/ddmas_pkg.sv
// Purpose: shared constants for the distributed dma slave control block
// Assumes: 8-bit register data, 4-bit offset inside the 16-byte window
// Notes: offsets are relative to the window base
package ddmas_pkg;
    // ******************************
    // window layout
    // ******************************
    localparam logic [3:0] DDMAS_OFF_ADDR = 4'h0;
    localparam logic [3:0] DDMAS_OFF_PAGE = 4'h2;
    localparam logic [3:0] DDMAS_OFF_COUNT = 4'h4;
    localparam logic [3:0] DDMAS_OFF_CMD_STAT = 4'h8;
    localparam logic [3:0] DDMAS_OFF_SWREQ = 4'h9;
    localparam logic [3:0] DDMAS_OFF_MODE = 4'hB;
    localparam logic [3:0] DDMAS_OFF_CLEAR = 4'hD;
    localparam logic [3:0] DDMAS_OFF_IGNORE = 4'hF;
    localparam int DDMAS_WIN_BASE_LSB = 4;
    // ******************************
    // field positions
    // ******************************
    localparam int DDMAS_CMD_DISABLE_BIT = 2;
    localparam int DDMAS_MODE_SEL_LSB = 6;
    localparam int DDMAS_MODE_DIR_BIT = 5;
    localparam int DDMAS_MODE_RELOAD_BIT = 4;
    localparam int DDMAS_MODE_XFER_LSB = 2;
    localparam int DDMAS_IGNORE_BIT = 0;
    // ******************************
    // reset values and step sizes
    // ******************************
    localparam logic DDMAS_CMD_RESET = 1'b0;
    localparam logic [5:0] DDMAS_MODE_RESET = 6'h00;
    localparam logic DDMAS_IGNORE_RESET = 1'b0;
    localparam logic [15:0] DDMAS_WORD_RESET = 16'h0000;
    localparam logic [7:0] DDMAS_BYTE_RESET = 8'h00;
    localparam logic [15:0] DDMAS_STEP_8BIT = 16'h0001;
    localparam logic [15:0] DDMAS_STEP_16BIT = 16'h0002;
    // ******************************
    // encodings
    // ******************************
    typedef enum logic [1:0] {
        DDMAS_MODE_DEMAND = 2'b00,
        DDMAS_MODE_SINGLE = 2'b01,
        DDMAS_MODE_BLOCK = 2'b10,
        DDMAS_MODE_RSVD = 2'b11
    } ddmas_mode_t;
    typedef enum logic [1:0] {
        DDMAS_XFER_NONE = 2'b00,
        DDMAS_XFER_TO_MEM = 2'b01,
        DDMAS_XFER_FROM_MEM = 2'b10,
        DDMAS_XFER_RSVD = 2'b11
    } ddmas_xfer_t;
    typedef enum logic [1:0] {
        DDMAS_ST_IDLE = 2'b00,
        DDMAS_ST_ACTIVE = 2'b01,
        DDMAS_ST_DONE = 2'b10
    } ddmas_state_t;
endpackage

//--- core/ddmas_sync.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: one clock domain
// Notes: first stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module ddmas_sync (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic async_in,
    output logic sync_out
);
    logic stage1;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            stage1 <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule
`default_nettype wire

//--- core/ddmas_ctrl.sv
// Purpose: control and status registers of a single-channel distributed dma slave
// Assumes: simple synchronous i/o port (16-byte window), 8-bit data, clk 125 MHz
// Notes: address/page/count registers are held here only to run the channel
`timescale 1ns/1ps
`default_nettype none
module ddmas_ctrl
    import ddmas_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [11:0] io_window_base_in,
    input wire logic io_sel_in,
    input wire logic io_wr_in,
    input wire logic io_rd_in,
    input wire logic [15:0] io_addr_in,
    input wire logic [7:0] io_wdata_in,
    output logic [7:0] io_rdata_out,
    output logic io_hit_out,
    input wire logic card_dma_request_in,
    input wire logic card_removed_in,
    input wire logic wide_mode_in,
    input wire logic xfer_done_in,
    output logic xfer_req_out,
    output logic to_memory_out,
    output logic from_memory_out,
    output logic [23:0] mem_addr_out,
    output logic terminal_count_out,
    output var ddmas_pkg::ddmas_mode_t transfer_mode_out
);
    import ddmas_pkg::*;

    // ******************************
    // pin synchronisers
    // ******************************
    // pins are asynchronous to the bus clock, so status trails the card by two cycles
    logic card_dma_request;
    logic card_removed;

    ddmas_sync u_req_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .async_in(card_dma_request_in),
        .sync_out(card_dma_request)
    );

    ddmas_sync u_rem_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .async_in(card_removed_in),
        .sync_out(card_removed)
    );

    // ******************************
    // address decode
    // ******************************
    function automatic logic hit_at(input logic [15:0] addr, input logic [11:0] base,
                                    input logic [3:0] off);
        hit_at = (addr[15:DDMAS_WIN_BASE_LSB] == base) && (addr[3:0] == off);
    endfunction

    wire in_window = io_sel_in &&
        (io_addr_in[15:DDMAS_WIN_BASE_LSB] == io_window_base_in);
    wire [3:0] offset = io_addr_in[3:0];
    wire acc_wr = io_sel_in && io_wr_in;
    wire acc_rd = io_sel_in && io_rd_in;
    wire wr_addr_lo = acc_wr && hit_at(io_addr_in, io_window_base_in, DDMAS_OFF_ADDR);
    wire wr_addr_hi = acc_wr && hit_at(io_addr_in, io_window_base_in, DDMAS_OFF_ADDR + 4'h1);
    wire wr_page = acc_wr && hit_at(io_addr_in, io_window_base_in, DDMAS_OFF_PAGE);
    wire wr_cnt_lo = acc_wr && hit_at(io_addr_in, io_window_base_in, DDMAS_OFF_COUNT);
    wire wr_cnt_hi = acc_wr && hit_at(io_addr_in, io_window_base_in, DDMAS_OFF_COUNT + 4'h1);
    wire wr_cmd = acc_wr && hit_at(io_addr_in, io_window_base_in, DDMAS_OFF_CMD_STAT);
    wire wr_swreq = acc_wr && hit_at(io_addr_in, io_window_base_in, DDMAS_OFF_SWREQ);
    wire wr_mode = acc_wr && hit_at(io_addr_in, io_window_base_in, DDMAS_OFF_MODE);
    wire wr_clear = acc_wr && hit_at(io_addr_in, io_window_base_in, DDMAS_OFF_CLEAR);
    wire wr_ignore = acc_wr && hit_at(io_addr_in, io_window_base_in, DDMAS_OFF_IGNORE);
    wire rd_status = acc_rd && hit_at(io_addr_in, io_window_base_in, DDMAS_OFF_CMD_STAT);

    // ******************************
    // registers
    // ******************************
    logic controller_disable;
    ddmas_mode_t transfer_mode_select;
    logic address_direction;
    logic reload_on_completion;
    ddmas_xfer_t transfer_direction;
    logic request_ignore;
    logic completion_flags;
    logic sw_request;
    logic [15:0] base_addr;
    logic [15:0] cur_addr;
    logic [7:0] page;
    logic [15:0] base_count;
    logic [15:0] cur_count;
    ddmas_state_t state;

    // master clear resets every dma register but the mask during removal and the completion flag on a same-cycle terminal count
    wire soft_clear = wr_clear;

    // ******************************
    // channel sequencing
    // ******************************
    wire enabled = !controller_disable;
    wire card_req_ok = card_dma_request && !request_ignore;
    wire is_block = (transfer_mode_select == DDMAS_MODE_BLOCK);
    // software requests only take effect in block mode
    wire sw_req_ok = sw_request && is_block;
    wire to_mem_sel = (transfer_direction == DDMAS_XFER_TO_MEM);
    wire from_mem_sel = (transfer_direction == DDMAS_XFER_FROM_MEM);
    wire type_ok = to_mem_sel || from_mem_sel;
    wire mode_ok = (transfer_mode_select != DDMAS_MODE_RSVD);
    wire want = enabled && type_ok && mode_ok && (card_req_ok || sw_req_ok);
    wire [15:0] step = wide_mode_in ? DDMAS_STEP_16BIT : DDMAS_STEP_8BIT;
    // a leftover count below one step still ends the run instead of wrapping
    wire count_exhausted = (cur_count <= step);
    wire beat = (state == DDMAS_ST_ACTIVE) && xfer_done_in;
    wire tc_event = beat && count_exhausted;
    wire [15:0] next_addr = address_direction ? (cur_addr - step)
                                              : (cur_addr + step);
    wire [15:0] next_count = cur_count - step;

    ddmas_state_t next_state;
    always_comb begin
        next_state = state;
        unique case (state)
            DDMAS_ST_IDLE: begin
                if (want) begin
                    next_state = DDMAS_ST_ACTIVE;
                end
            end
            DDMAS_ST_ACTIVE: begin
                if (tc_event) begin
                    next_state = reload_on_completion ? DDMAS_ST_IDLE
                                                      : DDMAS_ST_DONE;
                end else if (!want) begin
                    next_state = DDMAS_ST_IDLE;
                end else if (beat && transfer_mode_select == DDMAS_MODE_SINGLE) begin
                    next_state = DDMAS_ST_IDLE;
                end
            end
            DDMAS_ST_DONE: begin
                // parked until master clear or reset, so software must rearm the channel
                next_state = DDMAS_ST_DONE;
            end
            default: begin
                next_state = DDMAS_ST_IDLE;
            end
        endcase
    end

    // ******************************
    // register updates
    // ******************************
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            controller_disable <= DDMAS_CMD_RESET;
        end else if (soft_clear) begin
            controller_disable <= DDMAS_CMD_RESET;
        end else if (wr_cmd) begin
            controller_disable <= io_wdata_in[DDMAS_CMD_DISABLE_BIT];
        end
    end

    // mode register: reserved patterns are kept as written and refused where used
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            transfer_mode_select <= ddmas_mode_t'(DDMAS_MODE_RESET[5:4]);
            address_direction <= DDMAS_MODE_RESET[3];
            reload_on_completion <= DDMAS_MODE_RESET[2];
            transfer_direction <= ddmas_xfer_t'(DDMAS_MODE_RESET[1:0]);
        end else if (soft_clear) begin
            transfer_mode_select <= ddmas_mode_t'(DDMAS_MODE_RESET[5:4]);
            address_direction <= DDMAS_MODE_RESET[3];
            reload_on_completion <= DDMAS_MODE_RESET[2];
            transfer_direction <= ddmas_xfer_t'(DDMAS_MODE_RESET[1:0]);
        end else if (wr_mode) begin
            transfer_mode_select <=
                ddmas_mode_t'(io_wdata_in[DDMAS_MODE_SEL_LSB +: 2]);
            address_direction <= io_wdata_in[DDMAS_MODE_DIR_BIT];
            reload_on_completion <= io_wdata_in[DDMAS_MODE_RELOAD_BIT];
            transfer_direction <=
                ddmas_xfer_t'(io_wdata_in[DDMAS_MODE_XFER_LSB +: 2]);
        end
    end

    // software request: armed by any write, dropped when the run completes
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sw_request <= 1'b0;
        end else if (soft_clear) begin
            sw_request <= 1'b0;
        end else if (wr_swreq) begin
            sw_request <= 1'b1;
        end else if (tc_event) begin
            sw_request <= 1'b0;
        end
    end

    // mask: hardware set on removal wins over a software clear
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            request_ignore <= DDMAS_IGNORE_RESET;
        end else if (card_removed) begin
            request_ignore <= 1'b1;
        end else if (soft_clear) begin
            request_ignore <= DDMAS_IGNORE_RESET;
        end else if (wr_ignore) begin
            request_ignore <= io_wdata_in[DDMAS_IGNORE_BIT];
        end
    end

    // completion flag: a new terminal count beats a read-clear in the same cycle
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            completion_flags <= 1'b0;
        end else if (tc_event) begin
            completion_flags <= 1'b1;
        end else if (rd_status || soft_clear) begin
            completion_flags <= 1'b0;
        end
    end

    // channel state
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state <= DDMAS_ST_IDLE;
        end else if (soft_clear) begin
            state <= DDMAS_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // address, page and count: kept so the channel can run and reload
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            base_addr <= DDMAS_WORD_RESET;
            cur_addr <= DDMAS_WORD_RESET;
            base_count <= DDMAS_WORD_RESET;
            cur_count <= DDMAS_WORD_RESET;
            page <= DDMAS_BYTE_RESET;
        end else if (soft_clear) begin
            base_addr <= DDMAS_WORD_RESET;
            cur_addr <= DDMAS_WORD_RESET;
            base_count <= DDMAS_WORD_RESET;
            cur_count <= DDMAS_WORD_RESET;
            page <= DDMAS_BYTE_RESET;
        end else begin
            if (wr_addr_lo) begin
                base_addr[7:0] <= io_wdata_in;
                cur_addr[7:0] <= io_wdata_in;
            end else if (wr_addr_hi) begin
                base_addr[15:8] <= io_wdata_in;
                cur_addr[15:8] <= io_wdata_in;
            end else if (tc_event && reload_on_completion) begin
                cur_addr <= base_addr;
            end else if (beat) begin
                cur_addr <= next_addr;
            end
            if (wr_cnt_lo) begin
                base_count[7:0] <= io_wdata_in;
                cur_count[7:0] <= io_wdata_in;
            end else if (wr_cnt_hi) begin
                base_count[15:8] <= io_wdata_in;
                cur_count[15:8] <= io_wdata_in;
            end else if (tc_event && reload_on_completion) begin
                cur_count <= base_count;
            end else if (beat) begin
                cur_count <= next_count;
            end
            if (wr_page) begin
                page <= io_wdata_in;
            end
        end
    end

    // ******************************
    // read mux
    // ******************************
    wire [7:0] status_byte = {{4{card_dma_request}}, {4{completion_flags}}};
    wire [7:0] mode_byte = {transfer_mode_select, address_direction, reload_on_completion,
                            transfer_direction, 2'b00};
    wire [7:0] ignore_byte = {7'h00, request_ignore};
    logic [7:0] next_rdata;
    always_comb begin
        next_rdata = 8'h00;
        unique case (offset)
            DDMAS_OFF_ADDR: next_rdata = cur_addr[7:0];
            DDMAS_OFF_ADDR + 4'h1: next_rdata = cur_addr[15:8];
            DDMAS_OFF_PAGE: next_rdata = page;
            DDMAS_OFF_COUNT: next_rdata = cur_count[7:0];
            DDMAS_OFF_COUNT + 4'h1: next_rdata = cur_count[15:8];
            DDMAS_OFF_CMD_STAT: next_rdata = status_byte;
            DDMAS_OFF_MODE: next_rdata = mode_byte;
            DDMAS_OFF_IGNORE: next_rdata = ignore_byte;
            default: next_rdata = 8'h00;
        endcase
    end

    // ******************************
    // outputs
    // ******************************
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            io_rdata_out <= 8'h00;
            io_hit_out <= 1'b0;
            xfer_req_out <= 1'b0;
            to_memory_out <= 1'b0;
            from_memory_out <= 1'b0;
            mem_addr_out <= 24'h000000;
            terminal_count_out <= 1'b0;
            transfer_mode_out <= DDMAS_MODE_DEMAND;
        end else begin
            io_rdata_out <= (acc_rd && in_window) ? next_rdata : 8'h00;
            io_hit_out <= (acc_wr || acc_rd) && in_window;
            xfer_req_out <= (next_state == DDMAS_ST_ACTIVE);
            to_memory_out <= to_mem_sel;
            from_memory_out <= from_mem_sel;
            mem_addr_out <= {page, cur_addr};
            terminal_count_out <= tc_event;
            transfer_mode_out <= transfer_mode_select;
        end
    end
endmodule
`default_nettype wire

//--- sim/ddmas_chk.sv
// Purpose: port-level assertions for the dma slave control block
// Assumes: one clock, asynchronous active-high reset
// Notes: every window access is answered exactly one cycle after it is taken
`timescale 1ns/1ps
`default_nettype none
module ddmas_chk
    import ddmas_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [11:0] io_window_base_in,
    input wire logic io_sel_in,
    input wire logic io_wr_in,
    input wire logic io_rd_in,
    input wire logic [15:0] io_addr_in,
    input wire logic [7:0] io_wdata_in,
    input wire logic [7:0] io_rdata_out,
    input wire logic io_hit_out,
    input wire logic xfer_done_in,
    input wire logic to_memory_out,
    input wire logic from_memory_out,
    input wire logic terminal_count_out,
    input wire ddmas_mode_t transfer_mode_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // ****************************************
    // access decode
    // ****************************************
    wire in_win = io_addr_in[15:4] == io_window_base_in;
    wire hit = io_sel_in && (io_wr_in || io_rd_in) && in_win;
    wire [3:0] off = io_addr_in[3:0];
    wire rsvd = off inside {4'h3, 4'h6, 4'h7, 4'hA, 4'hC, 4'hE};
    sequence s_rd(logic [3:0] o);
        io_sel_in && io_rd_in && in_win && off == o;
    endsequence
    sequence s_wr(logic [3:0] o);
        io_sel_in && io_wr_in && in_win && off == o;
    endsequence
    // mode outputs are registered behind the mode register, hence two cycles
    property p_mode;
        logic [7:0] d;
        (s_wr(4'hB), d = io_wdata_in) |=> ##1
            (d[7:6] == 2'b11 || transfer_mode_out == d[7:6])
            && to_memory_out == (d[3:2] == 2'b01) && from_memory_out == (d[3:2] == 2'b10);
    endproperty
    // ****************************************
    // assertions
    // ****************************************
    hit_answer_a:
        assert property (hit |=> io_hit_out) else $error("no hit after window access");
    miss_quiet_a:
        assert property (!hit |=> !io_hit_out) else $error("hit without window access");
    rdata_idle_a:
        assert property (!(hit && io_rd_in) |=> io_rdata_out == 8'h00)
            else $error("read data without a read");
    rsvd_zero_a:
        assert property (s_rd(off) and rsvd |=> io_rdata_out == 8'h00)
            else $error("reserved offset read nonzero");
    mode_pad_a:
        assert property (s_rd(4'hB) |=> io_rdata_out[1:0] == 2'b00) else $error("mode pad bits set");
    mask_pad_a:
        assert property (s_rd(4'hF) |=> io_rdata_out[7:1] == 7'h00) else $error("mask pad bits set");
    stat_form_a:
        assert property (s_rd(4'h8) |=> io_rdata_out[7:4] inside {4'h0, 4'hF}
            && io_rdata_out[3:0] inside {4'h0, 4'hF}) else $error("status nibbles not uniform");
    dir_excl_a:
        assert property (!(to_memory_out && from_memory_out)) else $error("both directions set");
    tc_cause_a:
        assert property (terminal_count_out |-> $past(xfer_done_in))
            else $error("terminal count without a transfer");
    mode_write_a:
        assert property (p_mode) else $error("mode outputs do not follow write");
    clear_all_a:
        assert property (s_wr(4'hD) |=> ##1 transfer_mode_out == DDMAS_MODE_DEMAND
            && !to_memory_out && !from_memory_out) else $error("master clear left mode");
endmodule
`default_nettype wire

//--- sim/ddmas_card.sv
// Purpose: behavioural card and dma master facing the channel
// Assumes: one transfer at a time, finished after a programmable wait
// Notes: never starts in the cycle after its own completion pulse
`timescale 1ns/1ps
`default_nettype none
module ddmas_card (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic want_in,
    input wire logic gone_in,
    input wire logic [3:0] wait_in,
    input wire logic xfer_req_in,
    output logic card_dma_request_out,
    output logic card_removed_out,
    output logic xfer_done_out
);
    logic [4:0] cnt;
    // ****************************************
    // card pins and transfer completion
    // ****************************************
    assign card_dma_request_out = want_in;
    assign card_removed_out = gone_in;
    // request is stale in the cycle after a completion, so it is not taken then
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt <= 5'h00;
            xfer_done_out <= 1'b0;
        end else begin
            xfer_done_out <= cnt == 5'h01;
            if (cnt != 5'h00) begin
                cnt <= cnt - 5'h01;
            end else if (xfer_req_in && !xfer_done_out) begin
                cnt <= {1'b0, wait_in} + 5'h02;
            end
        end
    end
endmodule
`default_nettype wire

//--- sim/ddmas_ctrl_tb.sv
// Purpose: self-checking bench for the dma slave control block
// Assumes: window base 012h, card model answers every transfer request
// Notes: expected values come from the register map, never from outputs
`timescale 1ns/1ps
`default_nettype none
module ddmas_ctrl_tb;
    import ddmas_pkg::*;
    localparam logic [11:0] BASE = 12'h012;
    logic clk_in = 1'b0, rst_in = 1'b1, io_sel = 1'b0, io_wr = 1'b0, io_rd = 1'b0;
    logic [15:0] io_addr = 16'h0000;
    logic [7:0] io_wdata = 8'h00, io_rdata;
    logic io_hit, card_req, card_gone, xfer_done, xfer_req, to_mem, from_mem, tc;
    logic wide = 1'b0, want = 1'b0, gone = 1'b0, done_q = 1'b0;
    logic [3:0] wait_cyc = 4'h1;
    logic [23:0] mem_addr;
    ddmas_mode_t mode_out;
    int n_errors = 0, comparisons = 0, n_done = 0, n_cyc = 0, nd0, n_gap = 0, g0;
    int tc_q[$];
    logic [23:0] addr_q[$];
    logic [7:0] modes[4] = '{8'h07, 8'h6B, 8'hB3, 8'h13};
    logic [3:0] rsvd[6] = '{4'h3, 4'h6, 4'h7, 4'hA, 4'hC, 4'hE};
    always #4 clk_in = ~clk_in;
    ddmas_ctrl u_dut (
        .clk_in(clk_in), .rst_in(rst_in), .io_window_base_in(BASE), .io_sel_in(io_sel),
        .io_wr_in(io_wr), .io_rd_in(io_rd), .io_addr_in(io_addr), .io_wdata_in(io_wdata),
        .io_rdata_out(io_rdata), .io_hit_out(io_hit), .card_dma_request_in(card_req),
        .card_removed_in(card_gone), .wide_mode_in(wide), .xfer_done_in(xfer_done),
        .xfer_req_out(xfer_req), .to_memory_out(to_mem), .from_memory_out(from_mem),
        .mem_addr_out(mem_addr), .terminal_count_out(tc), .transfer_mode_out(mode_out));
    ddmas_card u_card (
        .clk_in(clk_in), .rst_in(rst_in), .want_in(want), .gone_in(gone), .wait_in(wait_cyc),
        .xfer_req_in(xfer_req), .card_dma_request_out(card_req),
        .card_removed_out(card_gone), .xfer_done_out(xfer_done));
    // ****************************************
    // monitor and tasks
    // ****************************************
    always @(posedge clk_in) begin
        n_cyc++;
        if (xfer_done) begin
            n_done++;
            addr_q.push_back(mem_addr);
        end
        if (tc) begin
            tc_q.push_back(n_done);
        end
        // request dropped right after a transfer that did not end the run
        if (done_q && !xfer_req && !tc) begin
            n_gap++;
        end
        done_q = xfer_done;
        if (n_cyc == 20000) begin
            n_errors++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic access(input logic [15:0] a, input logic w, input logic [7:0] d);
        @(posedge clk_in);
        io_sel <= 1'b1;
        io_wr <= w;
        io_rd <= !w;
        io_addr <= a;
        io_wdata <= d;
        @(posedge clk_in);
        io_sel <= 1'b0;
        io_wr <= 1'b0;
        io_rd <= 1'b0;
        #1;
    endtask
    task automatic wr(input logic [3:0] off, input logic [7:0] d);
        access({BASE, off}, 1'b1, d);
    endtask
    task automatic rd(input logic [3:0] off, input logic [7:0] exp);
        access({BASE, off}, 1'b0, 8'h00);
        check({23'h0, io_hit}, 24'h1);
        check({16'h0, io_rdata}, {16'h0, exp});
    endtask
    task automatic wait_tc(input int k);
        for (int i = 0; i < 400 && tc_q.size() < k; i++) @(posedge clk_in);
        #1;
        check(24'(tc_q.size()), 24'(k));
    endtask
    task automatic setup(input logic [7:0] mode, input logic [7:0] count);
        wr(4'h0, 8'h10);
        wr(4'h1, 8'h00);
        wr(4'h2, 8'h05);
        wr(4'h4, count);
        wr(4'h5, 8'h00);
        wr(4'hB, mode);
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        rd(4'h8, 8'h00);
        rd(4'hB, 8'h00);
        rd(4'hF, 8'h00);
        foreach (rsvd[i]) begin
            wr(rsvd[i], 8'hFF);
            rd(rsvd[i], 8'h00);
        end
        rd(4'hB, 8'h00);
        rd(4'hF, 8'h00);
        access({BASE + 12'h001, 4'h8}, 1'b0, 8'h00);
        check({23'h0, io_hit}, 24'h0);
        check({16'h0, io_rdata}, 24'h0);
        foreach (modes[i]) begin
            wr(4'hB, modes[i]);
            rd(4'hB, modes[i] & 8'hFC);
            check({22'h0, mode_out}, {22'h0, modes[i][7:6]});
            check({22'h0, from_mem, to_mem}, {22'h0, modes[i][3:2] == 2'b10,
                modes[i][3:2] == 2'b01});
        end
        wr(4'h8, 8'h04);
        rd(4'h8, 8'h00);
        setup(8'h04, 8'h03);
        @(posedge clk_in);
        want <= 1'b1;
        repeat (20) @(posedge clk_in);
        #1 check({23'h0, xfer_req}, 24'h0);
        wr(4'h8, 8'h00);
        wait_tc(1);
        check(24'(tc_q[0]), 24'd3);
        check(addr_q[0], 24'h050010);
        check(addr_q[2], 24'h050012);
        rd(4'h8, 8'hFF);
        rd(4'h8, 8'hF0);
        wr(4'hD, 8'h3C);
        rd(4'hB, 8'h00);
        rd(4'h8, 8'hF0);
        check({23'h0, xfer_req}, 24'h0);
        @(posedge clk_in);
        wide <= 1'b1;
        wait_cyc <= 4'h4;
        setup(8'h38, 8'h04);
        wait_tc(3);
        check(24'(tc_q[1] - tc_q[0]), 24'd2);
        check(24'(tc_q[2] - tc_q[1]), 24'd2);
        check({23'h0, addr_q[4] < addr_q[3]}, 24'h1);
        check(24'(n_gap), 24'd0);
        wr(4'hF, 8'h01);
        repeat (12) @(posedge clk_in);
        #1 nd0 = n_done;
        repeat (40) @(posedge clk_in);
        #1 check(24'(n_done - nd0), 24'd0);
        rd(4'hF, 8'h01);
        rd(4'h8, 8'hFF);
        @(posedge clk_in);
        want <= 1'b0;
        wide <= 1'b0;
        wr(4'hD, 8'h00);
        rd(4'h8, 8'h00);
        setup(8'h84, 8'h02);
        nd0 = n_done;
        wr(4'h9, 8'h5A);
        wait_tc(4);
        check(24'(tc_q[3] - nd0), 24'd2);
        wr(4'hD, 8'h00);
        setup(8'h44, 8'h02);
        nd0 = n_done;
        g0 = n_gap;
        @(posedge clk_in);
        want <= 1'b1;
        wait_tc(5);
        check(24'(tc_q[4] - nd0), 24'd2);
        check(24'(n_gap - g0), 24'd1);
        @(posedge clk_in);
        gone <= 1'b1;
        repeat (6) @(posedge clk_in);
        rd(4'hF, 8'h01);
        wr(4'hF, 8'h00);
        rd(4'hF, 8'h01);
        give_verdict();
    end
endmodule
bind ddmas_ctrl ddmas_chk u_chk (
    .clk_in(clk_in), .rst_in(rst_in), .io_window_base_in(io_window_base_in),
    .io_sel_in(io_sel_in), .io_wr_in(io_wr_in), .io_rd_in(io_rd_in), .io_addr_in(io_addr_in),
    .io_wdata_in(io_wdata_in), .io_rdata_out(io_rdata_out), .io_hit_out(io_hit_out),
    .xfer_done_in(xfer_done_in), .to_memory_out(to_memory_out),
    .from_memory_out(from_memory_out), .terminal_count_out(terminal_count_out),
    .transfer_mode_out(transfer_mode_out));
`default_nettype wire
